// file: pdl_lookup.sv
// Implementation choice: the APB register port.
`timescale 1ns/100ps
// Functional notes
// - Route by highest mismatching destination bit.
// - Lower table covers bits 7..0, index 0x0C.
// - Upper table covers bits 15..8, index 0x0D.
// - Four-bit entry n at bits 4*(n mod 8).
// - All entries read-write, reset to zero.
// - Enabled debug wire signals raise core call.
// - Enabled pull-down drives wire low in debug.
// - Debug config at 0x10, bits 31:2 reserved.
module pdl_lookup #(
	parameter int FIFO_DEPTH = pdl_pkg::FIFO_DEPTH
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pdl_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [pdl_pkg::ID_W-1:0] node_id,
	input wire logic hdr_valid,
	output logic hdr_ready,
	input wire logic [pdl_pkg::ID_W-1:0] hdr_dest_id,
	output logic dir_valid,
	input wire logic dir_ready,
	output logic [pdl_pkg::DIR_W-1:0] dir_code,
	output logic dir_local,
	input wire logic debug_mode,
	input wire logic debug_wire_in,
	output logic debug_wire_out,
	output logic debug_wire_oe_n,
	output logic core_debug_call
);
	localparam int IW = pdl_pkg::ID_W;
	localparam int DW = pdl_pkg::DIR_W;

	pdl_pkg::pdl_apb_t apb_state_r;
	logic [31:0] dir_low_r;
	logic [31:0] dir_high_r;
	logic [1:0] dbg_cfg_r;
	logic wr_en;
	logic fifo_valid;
	logic fifo_pop;
	logic [IW-1:0] fifo_dest;
	logic [DW-1:0] look_dir;
	logic look_local;
	logic debug_wire_d_r;

	// Entry extraction for mismatch bit n within one table
	function automatic logic [DW-1:0] pdl_entry(input logic [31:0] tbl, input int unsigned n);
		logic [DW-1:0] e;
		e = tbl[(n % pdl_pkg::ENTRIES) * DW +: DW];
		return e;
	endfunction : pdl_entry

	// Address decode shared by read mux and write strobes
	function automatic logic [1:0] pdl_decode(input logic [pdl_pkg::ADDR_W-1:0] a);
		logic [1:0] sel;
		sel = 2'h3;
		if (a == pdl_pkg::ADDR_DIR_LOW) begin
			sel = 2'h0;
		end else if (a == pdl_pkg::ADDR_DIR_HIGH) begin
			sel = 2'h1;
		end else if (a == pdl_pkg::ADDR_DBG_CFG) begin
			sel = 2'h2;
		end
		return sel;
	endfunction : pdl_decode

	// APB slave: one wait state, so pready and prdata are both flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_state_r <= pdl_pkg::PDL_IDLE;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			case (apb_state_r)
				pdl_pkg::PDL_IDLE: begin
					pready <= 1'b0;
					pslverr <= 1'b0;
					if (psel && penable) begin
						apb_state_r <= pdl_pkg::PDL_ACCESS;
						pready <= 1'b1;
						pslverr <= (pdl_decode(paddr) == 2'h3);
						case (pdl_decode(paddr))
							2'h0: begin
								prdata <= dir_low_r;
							end
							2'h1: begin
								prdata <= dir_high_r;
							end
							2'h2: begin
								prdata <= {30'h0000_0000, dbg_cfg_r};
							end
							default: begin
								prdata <= 32'h0000_0000;
							end
						endcase
					end
				end
				pdl_pkg::PDL_ACCESS: begin
					// Transfer completes here; drop ready so a back-to-back one waits again
					apb_state_r <= pdl_pkg::PDL_IDLE;
					pready <= 1'b0;
					pslverr <= 1'b0;
				end
				default: begin
					apb_state_r <= pdl_pkg::PDL_IDLE;
					pready <= 1'b0;
					pslverr <= 1'b0;
				end
			endcase
		end
	end

	// Writes take effect only at the completing edge
	assign wr_en = psel && penable && pready && pwrite;

	// Direction tables, full word writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_low_r <= pdl_pkg::DIR_RST;
			dir_high_r <= pdl_pkg::DIR_RST;
		end else if (wr_en) begin
			if (pdl_decode(paddr) == 2'h0) begin
				dir_low_r <= pwdata;
			end
			if (pdl_decode(paddr) == 2'h1) begin
				dir_high_r <= pwdata;
			end
		end
	end

	// Debug wire configuration; upper bits are not stored and read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dbg_cfg_r <= pdl_pkg::DBG_RST;
		end else if (wr_en && pdl_decode(paddr) == 2'h2) begin
			dbg_cfg_r <= pwdata[1:0];
		end
	end

	// Header queue absorbs bursts while the output stage is stalled
	pdl_fifo #(
		.WIDTH(IW),
		.DEPTH(FIFO_DEPTH)
	) u_hdr_fifo (
		.clk(pclk),
		.rst_n(presetn),
		.in_valid(hdr_valid),
		.in_ready(hdr_ready),
		.in_data(hdr_dest_id),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_dest)
	);

	// Priority search from bit 0 upward, last hit wins; a loop keeps it one expression deep per bit
	always_comb begin
		logic [IW-1:0] diff;
		diff = fifo_dest ^ node_id;
		look_dir = '0;
		look_local = (diff == '0);
		for (int unsigned i = 0; i < IW; i++) begin
			if (diff[i]) begin
				// Later (higher) bits overwrite, so the most significant mismatch wins
				look_dir = (i < pdl_pkg::ENTRIES) ? pdl_entry(dir_low_r, i) : pdl_entry(dir_high_r, i);
			end
		end
	end

	// Output stage advances when empty or when the consumer takes the result
	assign fifo_pop = fifo_valid && (!dir_valid || dir_ready);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_valid <= 1'b0;
			dir_code <= '0;
			dir_local <= 1'b0;
		end else if (!dir_valid || dir_ready) begin
			dir_valid <= fifo_valid;
			if (fifo_valid) begin
				dir_code <= look_dir;
				dir_local <= look_local;
			end
		end
	end

	// Pull-down: drive low only while the node is in debug mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			debug_wire_out <= 1'b0;
			debug_wire_oe_n <= 1'b1;
		end else begin
			debug_wire_out <= 1'b0;
			debug_wire_oe_n <= !(dbg_cfg_r[pdl_pkg::DBG_PD_BIT] && debug_mode);
		end
	end

	// Call on a falling edge of the wire, ignoring our own pull-down
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			debug_wire_d_r <= 1'b1;
			core_debug_call <= 1'b0;
		end else begin
			debug_wire_d_r <= debug_wire_in;
			core_debug_call <= dbg_cfg_r[pdl_pkg::DBG_CALL_BIT] && debug_wire_d_r && !debug_wire_in
				&& debug_wire_oe_n;
		end
	end
endmodule : pdl_lookup

// file: pdl_pkg.sv
package pdl_pkg;
	// Register indices as printed; byte address is four times the index
	localparam logic [7:0] IDX_DIR_LOW = 8'h0c;
	localparam logic [7:0] IDX_DIR_HIGH = 8'h0d;
	localparam logic [7:0] IDX_DBG_CFG = 8'h10;
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] ADDR_DIR_LOW = {2'h0, IDX_DIR_LOW, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_DIR_HIGH = {2'h0, IDX_DIR_HIGH, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_DBG_CFG = {2'h0, IDX_DBG_CFG, 2'h0};
	localparam int ID_W = 16;
	localparam int DIR_W = 4;
	localparam int ENTRIES = 8;
	localparam logic [31:0] DIR_RST = 32'h0000_0000;
	localparam int DBG_PD_BIT = 0;
	localparam int DBG_CALL_BIT = 1;
	localparam logic [1:0] DBG_RST = 2'h0;
	localparam int FIFO_DEPTH = 8;
	typedef enum logic [1:0] {PDL_IDLE, PDL_ACCESS, PDL_DONE} pdl_apb_t;
endpackage : pdl_pkg

// file: pdl_fifo.sv
`timescale 1ns/100ps
module pdl_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
	localparam logic [PW-1:0] LAST = (PW)'(DEPTH - 1);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr_r;
	logic [PW-1:0] rd_ptr_r;
	logic [PW:0] count_r;
	logic [PW:0] count_nxt;
	logic push;
	logic pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_valid = (count_r != '0);
	assign out_data = mem[rd_ptr_r];

	// Occupancy; ready is a flop so it can feed a top-level output directly
	always_comb begin
		count_nxt = count_r;
		if (push && !pop) begin
			count_nxt = count_r + 1'b1;
		end else if (pop && !push) begin
			count_nxt = count_r - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_r <= '0;
			in_ready <= 1'b1;
		end else begin
			count_r <= count_nxt;
			in_ready <= (count_nxt != FULL_CNT);
		end
	end

	// Pointers wrap at the depth, which need not be a power of two
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == LAST) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == LAST) ? '0 : rd_ptr_r + 1'b1;
			end
		end
	end

	// Storage has no reset; a word is only read after it was written
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end
endmodule : pdl_fifo

// file: pdl_lookup_sva.sv
`timescale 1ns/100ps
// Port-level checks of bus answer, result stream and debug wire
module pdl_lookup_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pdl_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic dir_valid,
	input wire logic dir_ready,
	input wire logic [pdl_pkg::DIR_W-1:0] dir_code,
	input wire logic dir_local,
	input wire logic debug_mode,
	input wire logic debug_wire_out,
	input wire logic debug_wire_oe_n,
	input wire logic core_debug_call
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// One wait state, answer stands one cycle
	property p_rdy; psel && penable && !pready |=> pready ##1 !pready; endproperty
	a_rdy: assert property (p_rdy) else $error("bad answer timing");
	property p_err; pready |-> pslverr == !(paddr inside {12'h030, 12'h034, 12'h040}); endproperty
	a_err: assert property (p_err) else $error("bad slave error");
	property p_rsv; pready && !pwrite && paddr == 12'h040 |-> prdata[31:2] == 30'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits set");
	// A stalled result must not move under the consumer
	property p_hold; dir_valid && !dir_ready |=> dir_valid && $stable(dir_code) && $stable(dir_local); endproperty
	a_hold: assert property (p_hold) else $error("result not held");
	property p_local; dir_valid && dir_local |-> dir_code == 4'h0; endproperty
	a_local: assert property (p_local) else $error("local with code");
	property p_oe; !debug_mode |=> debug_wire_oe_n; endproperty
	a_oe: assert property (p_oe) else $error("wire driven outside debug");
	property p_drv; !debug_wire_oe_n |-> !debug_wire_out && $past(debug_mode); endproperty
	a_drv: assert property (p_drv) else $error("wire driven wrong");
	property p_call; core_debug_call |=> !core_debug_call; endproperty
	a_call: assert property (p_call) else $error("call not a pulse");
endmodule : pdl_lookup_sva
bind pdl_lookup pdl_lookup_sva pdl_lookup_sva_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
	.pready, .pslverr, .dir_valid, .dir_ready, .dir_code, .dir_local, .debug_mode, .debug_wire_out,
	.debug_wire_oe_n, .core_debug_call);

// file: pdl_sink.sv
`timescale 1ns/100ps
module pdl_sink (
	input wire logic pclk,
	input wire logic stall,
	input wire logic dir_valid,
	input wire logic [pdl_pkg::DIR_W-1:0] dir_code,
	input wire logic dir_local,
	output logic dir_ready
);
	logic [4:0] q[$];
	// Stall models a busy outgoing link
	assign dir_ready = !stall;
	// Log accepted results in arrival order
	always @(posedge pclk) if (dir_valid && dir_ready) q.push_back({dir_local, dir_code});
endmodule : pdl_sink

// file: test_packet_direction_lookup.sv
`timescale 1ns/100ps
module test_packet_direction_lookup;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic hdr_valid = 1'h0, debug_mode = 1'h0, ext_n = 1'h1, stall = 1'h1, err_s;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, hdr_ready, dir_valid, dir_ready, dir_local, oe_n, w_out, call;
	logic [15:0] node_id = 16'ha5a5, dest = 16'h0;
	logic [3:0] dir_code;
	logic [11:0] adr[3] = '{12'h030, 12'h034, 12'h040};
	logic [31:0] wv[3] = '{32'h76543210, 32'hfedcba98, 32'hffffffff};
	logic [31:0] ev[3] = '{32'h76543210, 32'hfedcba98, 32'h3};
	int err_count = 0, tests_run = 0, calls = 0, full = 0;
	// Pulled-up wire; our own drive wins
	wire logic dw = oe_n ? ext_n : w_out;
	always #5 pclk = !pclk;
	// Count only out of reset; an unknown call before the first edge would stick in the sum
	always @(posedge pclk) if (presetn) calls <= calls + call;
	pdl_lookup pdl_lookup_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .node_id(node_id),
		.hdr_valid(hdr_valid), .hdr_ready(hdr_ready), .hdr_dest_id(dest), .dir_valid(dir_valid),
		.dir_ready(dir_ready), .dir_code(dir_code), .dir_local(dir_local), .debug_mode(debug_mode),
		.debug_wire_in(dw), .debug_wire_out(w_out), .debug_wire_oe_n(oe_n), .core_debug_call(call));
	pdl_sink pdl_sink_inst (.pclk(pclk), .stall(stall), .dir_valid(dir_valid), .dir_code(dir_code),
		.dir_local(dir_local), .dir_ready(dir_ready));
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	// Leading edge keeps an idle cycle between transfers
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (!pready) @(posedge pclk);
		rd = prdata;
		err_s = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	// A refusal releases the stall so the queue can drain
	task send(input logic [15:0] d);
		hdr_valid <= 1'h1;
		dest <= d;
		@(posedge pclk);
		while (!hdr_ready) begin
			full = 1;
			stall <= 1'h0;
			@(posedge pclk);
		end
	endtask : send
	task end_of_test;
		$display("errors %0d checks %0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test
	initial begin
		#200000;
		err_count++;
		end_of_test;
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		// Reset values, then write and read back, then an unmapped place
		for (int i = 0; i < 3; i++) begin
			apb(1'h0, adr[i], 32'h0);
			chk(rd, 32'h0);
			apb(1'h1, adr[i], wv[i]);
			apb(1'h0, adr[i], 32'h0);
			chk(rd, ev[i]);
		end
		apb(1'h1, 12'h044, 32'hffffffff);
		apb(1'h0, 12'h044, 32'h0);
		chk({rd[31:1], err_s}, 32'h1);
		// Every mismatch position with all lower bits flipped, then an exact match
		for (int n = 0; n < 17; n++) send(n < 16 ? node_id ^ (16'hffff >> (15 - n)) : node_id);
		hdr_valid <= 1'h0;
		chk(full, 32'h1);
		for (int k = 0; k < 100 && pdl_sink_inst.q.size() < 17; k++) @(posedge pclk);
		// The last accept and this loop share an edge; let the output stage settle first
		repeat (2) @(posedge pclk);
		for (int n = 0; n < 17; n++) chk(pdl_sink_inst.q[n], n);
		chk({hdr_ready, dir_valid}, 32'h2);
		// Own pull-down must not call the core
		debug_mode <= 1'h1;
		repeat (3) @(posedge pclk);
		chk({oe_n, calls[0]}, 32'h0);
		// Let the wire float back high before the far side pulls it, else no edge is seen
		debug_mode <= 1'h0;
		repeat (3) @(posedge pclk);
		ext_n <= 1'h0;
		repeat (3) @(posedge pclk);
		ext_n <= 1'h1;
		repeat (3) @(posedge pclk);
		chk({oe_n, calls[1:0]}, 32'h5);
		apb(1'h1, 12'h040, 32'h0);
		debug_mode <= 1'h1;
		ext_n <= 1'h0;
		repeat (4) @(posedge pclk);
		chk({oe_n, calls[1:0]}, 32'h5);
		end_of_test;
	end
endmodule : test_packet_direction_lookup
